// ---- hdl/aecr_readout.sv ----
// What this block does
// - Select pins pick internal, 1.2 V or 4.096 V reference
// - Both select pins low means power-down
// - Strobes accepted right after leaving power-down
// - Conversion starts on strobe rising edge, LVDS or CMOS
// - Echo clock is buffered copy of read clock
// - Data changes on echo falling edge, host samples rising
// - Strobes ignored until conversion phase ends
// - Data and echo held low deadline to MSB-ready
// - Result shifted MSB first, two's complement
// - Echo pin tied low selects self-clocked mode
`timescale 1ns/1ps

module aecr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,  // System clock
    input  wire logic             rst_n,     // Asynchronous reset
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data,   // Word written
    output logic                  out_valid, // Word available
    input  wire logic             out_ready, // Reader takes word
    output logic      [WIDTH-1:0] out_data   // Oldest word
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module aecr_readout
    import aecr_pkg::*;
#(
    parameter int WIDTH = WORD_BITS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             core_clk,         // 10 MHz clock
    input  wire logic             rst_n,            // Asynchronous reset
    input  wire logic             ref_select_hi,    // Reference select, upper pin
    input  wire logic             ref_select_lo,    // Reference select, lower pin
    input  wire logic             convert_strobe_p, // Strobe, positive or CMOS pin
    input  wire logic             convert_strobe_n, // Strobe, negative pin
    input  wire logic             strobe_lvds,      // High: strobe is a differential pair
    input  wire logic             echo_pin_strap,   // Low: echo pin tied to ground
    input  wire logic             read_clk,         // Host read clock
    input  wire logic [WIDTH-1:0] conv_code,        // Code from converter core
    output logic                  serial_data,      // Serial result
    output logic                  echo_clock,       // Echoed read clock
    output aecr_ref_mode_t        ref_mode,         // Decoded reference mode
    output logic                  power_down,       // Converter powered down
    output logic                  self_clocked,     // Echo readout disabled
    output logic                  converting,       // Conversion phase running
    output logic                  result_dropped    // Pulse: word lost to full buffer
);
    logic [1:0]       sel_hi_sync;
    logic [1:0]       sel_lo_sync;
    logic [1:0]       stb_p_sync;
    logic [1:0]       stb_n_sync;
    logic [1:0]       rclk_sync;
    logic [1:0]       strap_sync;
    logic [1:0]       lvds_sync;
    logic             rclk_prev;
    logic             stb_prev;
    logic             stb_level;
    logic             stb_rise;
    logic             rclk_fall;
    logic [CNT_W-1:0] conv_cnt;
    logic             conv_last;
    logic             blank;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic [WIDTH-1:0] fifo_out_data;
    logic             load;
    logic [WIDTH-1:0] shreg;
    logic [BITS_W-1:0] bits_left;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_hi_sync <= 2'h0;
            sel_lo_sync <= 2'h0;
            stb_p_sync  <= 2'h0;
            stb_n_sync  <= 2'h0;
            rclk_sync   <= 2'h0;
            strap_sync  <= 2'h0;
            lvds_sync   <= 2'h0;
        end else begin
            sel_hi_sync <= {sel_hi_sync[0], ref_select_hi};
            sel_lo_sync <= {sel_lo_sync[0], ref_select_lo};
            stb_p_sync  <= {stb_p_sync[0], convert_strobe_p};
            stb_n_sync  <= {stb_n_sync[0], convert_strobe_n};
            rclk_sync   <= {rclk_sync[0], read_clk};
            strap_sync  <= {strap_sync[0], echo_pin_strap};
            lvds_sync   <= {lvds_sync[0], strobe_lvds};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_mode     <= AECR_POWER_DOWN;
            power_down   <= 1'b1;
            self_clocked <= 1'b1;
        end else begin
            unique case ({sel_hi_sync[1], sel_lo_sync[1]})
                2'b11:   ref_mode <= AECR_REF_INTERNAL;
                2'b01:   ref_mode <= AECR_REF_EXT_BUFFERED;
                2'b10:   ref_mode <= AECR_REF_EXT_DIRECT;
                2'b00:   ref_mode <= AECR_POWER_DOWN;
            endcase
            power_down   <= !sel_hi_sync[1] && !sel_lo_sync[1];
            self_clocked <= !strap_sync[1];
        end
    end

    // Pair level only counts when the halves disagree; a CMOS strobe uses the positive pin
    assign stb_level = lvds_sync[1] ? (stb_p_sync[1] && !stb_n_sync[1]) : stb_p_sync[1];
    assign stb_rise  = stb_level && !stb_prev;
    assign rclk_fall = rclk_prev && !rclk_sync[1];
    assign conv_last = (conv_cnt == CNT_W'(MSB_READY_CYC - 1));
    assign blank     = converting && (conv_cnt >= CNT_W'(READ_DEADLINE_CYC));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stb_prev  <= 1'b0;
            rclk_prev <= 1'b0;
        end else begin
            stb_prev  <= stb_level;
            rclk_prev <= rclk_sync[1];
        end
    end

    // No wake-up lockout: the host owns settling time, results come at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            converting <= 1'b0;
            conv_cnt   <= CNT_RESET;
        end else if (converting) begin
            if (conv_last) begin
                converting <= 1'b0;
                conv_cnt   <= CNT_RESET;
            end else begin
                conv_cnt <= conv_cnt + 1'b1;
            end
        end else if (stb_rise && !power_down) begin
            converting <= 1'b1;
            conv_cnt   <= CNT_RESET;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_dropped <= 1'b0;
        end else begin
            result_dropped <= converting && conv_last && !fifo_in_ready;
        end
    end

    aecr_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (converting && conv_last),
        .in_ready  (fifo_in_ready),
        .in_data   (conv_code),
        .out_valid (fifo_out_valid),
        .out_ready (load),
        .out_data  (fifo_out_data)
    );

    // New word enters the shifter only between bursts and outside the blank window;
    // while self-clocked the words stay buffered instead of being popped and lost
    assign load = fifo_out_valid && (bits_left == BITS_RESET) && !blank && !converting && !self_clocked;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg       <= '0;
            bits_left   <= BITS_RESET;
            serial_data <= 1'b0;
            echo_clock  <= 1'b0;
        end else if (self_clocked) begin
            bits_left   <= BITS_RESET;
            serial_data <= 1'b0;
            echo_clock  <= 1'b0;
        end else if (blank) begin
            bits_left   <= BITS_RESET;
            serial_data <= 1'b0;
            echo_clock  <= 1'b0;
        end else begin
            echo_clock <= rclk_sync[1];
            if (load) begin
                shreg       <= fifo_out_data;
                bits_left   <= BITS_W'(WIDTH);
                serial_data <= fifo_out_data[WIDTH-1];
            end else if (rclk_fall && bits_left != BITS_RESET) begin
                shreg       <= {shreg[WIDTH-2:0], 1'b0};
                bits_left   <= bits_left - 1'b1;
                serial_data <= (bits_left > 5'h01) ? shreg[WIDTH-2] : 1'b0;
            end
        end
    end

    // Helper for the phase length check: cycles spent in the current phase
    logic [CNT_W-1:0] phase_len;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_len <= CNT_RESET;
        end else if (converting) begin
            phase_len <= phase_len + 1'b1;
        end else begin
            phase_len <= CNT_RESET;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_ref_decode_mode: assert property (sel_hi_sync[1] && !sel_lo_sync[1] |=> ref_mode == AECR_REF_EXT_DIRECT)
        else $error("reference mode decode wrong");
    a_power_down_both: assert property (!sel_hi_sync[1] && !sel_lo_sync[1] |=> power_down && ref_mode == AECR_POWER_DOWN)
        else $error("power-down not entered");
    a_strobe_start_conv: assert property (stb_rise && !converting && !power_down |=> converting && conv_cnt == 8'h00)
        else $error("strobe edge did not start conversion");
    a_conv_phase_len: assert property ($fell(converting) |-> phase_len == CNT_W'(MSB_READY_CYC))
        else $error("conversion phase length wrong");
    a_conv_no_overrun: assert property (converting |-> phase_len < CNT_W'(MSB_READY_CYC))
        else $error("conversion phase ran too long");
    a_echo_copy_clk: assert property (!self_clocked && !blank |=> echo_clock == $past(rclk_sync[1]))
        else $error("echo clock not a copy of read clock");
    a_shift_on_fall: assert property (!self_clocked && !blank && !load && rclk_fall && bits_left > 5'h01
        |=> serial_data == $past(shreg[WIDTH-2]) && bits_left == $past(bits_left) - 5'h01)
        else $error("data not advanced on falling edge");
    a_msb_first_load: assert property (load && !self_clocked |=> serial_data == $past(fifo_out_data[WIDTH-1])
        && bits_left == 5'h10)
        else $error("MSB not presented first");
    a_blank_outputs_low: assert property (blank |=> !serial_data && !echo_clock && bits_left == 5'h00)
        else $error("outputs not parked low in blank window");
    a_self_clk_quiet: assert property (self_clocked |=> !echo_clock && !serial_data)
        else $error("echo outputs active in self-clocked mode");

    c_conversion_done: cover property (converting && conv_last && fifo_in_ready);
    c_full_burst:      cover property (bits_left == 5'h01 && rclk_fall && !blank);
    c_ignored_strobe:  cover property (converting && stb_rise);
    c_discarded_word:  cover property (blank && bits_left != 5'h00);
endmodule

// ---- hdl/aecr_pkg.sv ----
package aecr_pkg;

    // Timing of the conversion phase, figures in ns, counted on core_clk
    localparam int CLK_PERIOD_NS     = 100;
    localparam int MSB_READY_NS      = 1000;
    localparam int READ_DEADLINE_NS  = 300;

    // Least time rounds up, longest time rounds down, never below one cycle
    localparam int MSB_READY_CYC     = (MSB_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_DEADLINE_RAW = READ_DEADLINE_NS / CLK_PERIOD_NS;
    localparam int READ_DEADLINE_CYC = (READ_DEADLINE_RAW < 1) ? 1 : READ_DEADLINE_RAW;

    localparam int WORD_BITS         = 16;
    localparam int FIFO_DEPTH        = 16;
    localparam int CNT_W             = 8;
    localparam int BITS_W            = 5;

    localparam logic [CNT_W-1:0]     CNT_RESET  = 8'h00;
    localparam logic [BITS_W-1:0]    BITS_RESET = 5'h00;

    typedef enum logic [1:0] {
        AECR_POWER_DOWN,
        AECR_REF_EXT_DIRECT,
        AECR_REF_EXT_BUFFERED,
        AECR_REF_INTERNAL
    } aecr_ref_mode_t;

endpackage

// ---- test/aecr_host_model.sv ----
`timescale 1ns/1ps

module aecr_host_model (
    input  wire logic        echo_clock,  // Echoed read clock
    input  wire logic        serial_data, // Serial result
    output logic             read_clk,    // Burst read clock
    output logic [15:0]      word         // Last whole word
);
    logic [15:0] shreg;
    int          nbits;

    initial begin
        read_clk = 1'b0;
        word = 16'h0000;
        shreg = 16'h0000;
        nbits = 0;
    end

    // Caller starts bursts only after the conversion phase ends
    task automatic burst(input int pulses);
        nbits = 0;
        #137;
        repeat (pulses) begin
            read_clk = 1'b1;
            #400;
            read_clk = 1'b0;
            #400;
        end
        // Echo lags three core edges; wait for the last one to return
        #600;
    endtask

    always @(posedge echo_clock) begin
        shreg = {shreg[14:0], serial_data};
        nbits = nbits + 1;
        if (nbits == 16) word = shreg;
    end
endmodule

// ---- test/tb_aecr_readout.sv ----
`timescale 1ns/1ps

module tb_aecr_readout;
    import aecr_pkg::*;
    logic           core_clk, rst_n, ref_select_hi, ref_select_lo;
    logic           convert_strobe_p, convert_strobe_n, strobe_lvds, echo_pin_strap;
    logic           read_clk, serial_data, echo_clock, power_down, self_clocked;
    logic           converting, result_dropped;
    logic [15:0]    conv_code, word;
    aecr_ref_mode_t ref_mode;
    int             errors, comparisons, high_cycles, drops;

    aecr_readout uut (.core_clk(core_clk), .rst_n(rst_n), .ref_select_hi(ref_select_hi),
        .ref_select_lo(ref_select_lo), .convert_strobe_p(convert_strobe_p),
        .convert_strobe_n(convert_strobe_n), .strobe_lvds(strobe_lvds), .echo_pin_strap(echo_pin_strap),
        .read_clk(read_clk), .conv_code(conv_code), .serial_data(serial_data), .echo_clock(echo_clock),
        .ref_mode(ref_mode), .power_down(power_down), .self_clocked(self_clocked),
        .converting(converting), .result_dropped(result_dropped));
    aecr_host_model host (.echo_clock(echo_clock), .serial_data(serial_data), .read_clk(read_clk), .word(word));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Sampled off the active edge so the count never races the design
    always @(negedge core_clk) begin
        if (converting === 1'b1) high_cycles++;
        if (result_dropped === 1'b1) drops++;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Second pulse lands inside the phase and must change nothing
    task automatic convert(input logic [15:0] code, input int exp_cyc);
        int h0;
        h0 = high_cycles;
        @(negedge core_clk);
        conv_code = code;
        convert_strobe_p = 1'b1;
        convert_strobe_n = 1'b0;
        cycles(3);
        convert_strobe_p = 1'b0;
        convert_strobe_n = 1'b1;
        cycles(2);
        convert_strobe_p = 1'b1;
        convert_strobe_n = 1'b0;
        cycles(2);
        convert_strobe_p = 1'b0;
        convert_strobe_n = 1'b1;
        cycles(1);
        if (exp_cyc != 0) check({14'h0000, serial_data, echo_clock}, 16'h0000);
        cycles(6);
        check(16'(high_cycles - h0), 16'(exp_cyc));
    endtask

    task automatic read_word(input logic [15:0] exp);
        host.burst(16);
        check(word, exp);
        @(negedge core_clk);
    endtask

    task automatic t_ref;
        logic [1:0] exp_mode [4];
        exp_mode = '{2'h0, 2'h2, 2'h1, 2'h3};
        for (int i = 0; i < 4; i++) begin
            {ref_select_hi, ref_select_lo} = 2'(i);
            cycles(4);
            check({14'h0000, ref_mode}, {14'h0000, exp_mode[i]});
            check({15'h0000, power_down}, {15'h0000, i == 0});
        end
        $display("test ref_decode done");
    endtask

    task automatic t_wake;
        {ref_select_hi, ref_select_lo} = 2'h0;
        cycles(4);
        convert(16'h5555, 0);
        {ref_select_hi, ref_select_lo} = 2'h2;
        cycles(3);
        // No wake-up wait: results still come back
        convert(16'h1111, 10);
        host.burst(16);
        convert(16'h8001, 10);
        read_word(16'h8001);
        convert(16'h7fff, 10);
        read_word(16'h7fff);
        $display("test wake_and_echo done");
    endtask

    task automatic t_lvds;
        int h0;
        strobe_lvds = 1'b1;
        h0 = high_cycles;
        convert_strobe_p = 1'b1;
        cycles(6);
        check(16'(high_cycles - h0), 16'h0000);
        convert_strobe_p = 1'b0;
        cycles(2);
        convert(16'hfffe, 10);
        read_word(16'hfffe);
        strobe_lvds = 1'b0;
        $display("test lvds_strobe done");
    endtask

    task automatic t_lost;
        convert(16'h1234, 10);
        host.burst(8);
        convert(16'hcafe, 10);
        read_word(16'hcafe);
        $display("test lost_word done");
    endtask

    task automatic t_fifo;
        echo_pin_strap = 1'b0;
        cycles(4);
        check({15'h0000, self_clocked}, 16'h0001);
        for (int i = 0; i < 17; i++) convert(16'h0100 + 16'(i), 10);
        check(16'(drops), 16'h0001);
        host.burst(4);
        cycles(1);
        check(16'(host.nbits), 16'h0000);
        echo_pin_strap = 1'b1;
        cycles(4);
        for (int i = 0; i < 16; i++) read_word(16'h0100 + 16'(i));
        $display("test buffer_fill_drain done");
    endtask

    task automatic report_and_stop;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #3000000;
        errors++;
        report_and_stop();
    end

    initial begin
        {rst_n, ref_select_hi, ref_select_lo, echo_pin_strap} = 4'h7;
        rst_n = 1'b0;
        {convert_strobe_p, convert_strobe_n, strobe_lvds} = 3'h2;
        conv_code = 16'h0000;
        errors = 0;
        comparisons = 0;
        high_cycles = 0;
        drops = 0;
        cycles(10);
        check({13'h0000, power_down, self_clocked, ref_mode == AECR_POWER_DOWN}, 16'h0007);
        cycles(10);
        rst_n = 1'b1;
        cycles(4);
        $display("test reset done");
        t_ref();
        t_wake();
        t_lvds();
        t_lost();
        t_fifo();
        report_and_stop();
    end
endmodule
